// *** hdl/cbf_pkg.sv ***
package cbf_pkg;
  localparam int unsigned NUM_BUF       = 16;
  localparam int unsigned WORDS_PER_BUF = 8;
  localparam int unsigned ADDR_W        = 12;
  localparam int unsigned KEY_W         = 29;
  localparam int unsigned DATA_W        = 64;

  // Word offsets inside one buffer, kept as register indices
  localparam logic [3:0] OFS_CTRL   = 4'h0;
  localparam logic [3:0] OFS_STAMP  = 4'h2;
  localparam logic [3:0] OFS_DATA78 = 4'h4;
  localparam logic [3:0] OFS_DATA56 = 4'h6;
  localparam logic [3:0] OFS_DATA34 = 4'h8;
  localparam logic [3:0] OFS_DATA12 = 4'hA;
  localparam logic [3:0] OFS_KEYLO  = 4'hC;
  localparam logic [3:0] OFS_KEYHI  = 4'hE;

  localparam logic [2:0] SLOT_CTRL   = OFS_CTRL[3:1];
  localparam logic [2:0] SLOT_STAMP  = OFS_STAMP[3:1];
  localparam logic [2:0] SLOT_DATA78 = OFS_DATA78[3:1];
  localparam logic [2:0] SLOT_DATA56 = OFS_DATA56[3:1];
  localparam logic [2:0] SLOT_DATA34 = OFS_DATA34[3:1];
  localparam logic [2:0] SLOT_DATA12 = OFS_DATA12[3:1];
  localparam logic [2:0] SLOT_KEYLO  = OFS_KEYLO[3:1];
  localparam logic [2:0] SLOT_KEYHI  = OFS_KEYHI[3:1];

  // Engine status register index, byte address is four times it
  localparam logic [9:0] STATUS_IDX = 10'h100;

  // Control and status word fields
  localparam int unsigned DLC_LSB       = 12;
  localparam int unsigned DLC_W         = 4;
  localparam logic [15:0] CTRL_WR_MASK  = 16'hF0FF;
  localparam logic [3:0]  MAX_BYTES     = 4'h8;

  // Key word fields
  localparam int unsigned STD_ID_LSB  = 5;
  localparam int unsigned STD_ID_W    = 11;
  localparam int unsigned STD_RTR_BIT = 4;
  localparam int unsigned SRR_BIT     = 4;
  localparam int unsigned IDE_BIT     = 3;
  localparam int unsigned EXT_MID_W   = 3;
  localparam int unsigned EXT_LOW_LSB = 1;
  localparam int unsigned EXT_LOW_W   = 15;
  localparam int unsigned EXT_RTR_BIT = 0;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** hdl/cbf_tx_unpack.sv ***
`timescale 1ns/1ps
module cbf_tx_unpack
  import cbf_pkg::*;
(
  input  wire logic [15:0]         ctrl_i,
  input  wire logic [15:0]         key_hi_i,
  input  wire logic [15:0]         key_lo_i,
  input  wire logic [3:0][15:0]    data_i,
  output logic      [KEY_W-1:0]    key_o,
  output logic                     ext_o,
  output logic                     remote_o,
  output logic                     srr_o,
  output logic      [3:0]          len_o,
  output logic      [DATA_W-1:0]   data_o
);
  // ===========================================================
  // Key and flags
  logic [3:0]        byte_count_code;
  logic [DATA_W-1:0] raw;

  assign byte_count_code   = ctrl_i[DLC_LSB +: DLC_W];
  assign ext_o = key_hi_i[IDE_BIT];
  assign key_o = ext_o ? {key_hi_i[STD_ID_LSB +: STD_ID_W],
                          key_hi_i[EXT_MID_W-1:0],
                          key_lo_i[EXT_LOW_LSB +: EXT_LOW_W]}
                       : {18'h0, key_hi_i[STD_ID_LSB +: STD_ID_W]};
  assign remote_o = ext_o ? key_lo_i[EXT_RTR_BIT] : key_hi_i[STD_RTR_BIT];
  assign srr_o    = ext_o;
  assign len_o    = remote_o ? 4'h0 : ((byte_count_code >= MAX_BYTES) ? MAX_BYTES : byte_count_code);
  // data_i[3] holds bytes one and two
  assign raw      = {data_i[3], data_i[2], data_i[1], data_i[0]};

  // ===========================================================
  // Byte masking
  genvar b;
  generate
    for (b = 0; b < 8; b++) begin : g_byte
      assign data_o[DATA_W-1-8*b -: 8] = (4'(b) < len_o) ? raw[DATA_W-1-8*b -: 8]
                                                         : 8'h00;
    end
  endgenerate
endmodule

// *** hdl/cbf_buffer_store.sv ***
// Register access over AXI4-Lite and the address map are this design's own decisions.
`timescale 1ns/1ps
module cbf_buffer_store #(
  parameter int unsigned NBUF = cbf_pkg::NUM_BUF
) (
  input  wire logic                          mclk_i,
  input  wire logic                          reset_i,
  // AXI4-Lite slave
  input  wire logic                          s_axi_awvalid_i,
  output logic                               s_axi_awready_o,
  input  wire logic [cbf_pkg::ADDR_W-1:0]    s_axi_awaddr_i,
  input  wire logic                          s_axi_wvalid_i,
  output logic                               s_axi_wready_o,
  input  wire logic [31:0]                   s_axi_wdata_i,
  input  wire logic [3:0]                    s_axi_wstrb_i,
  output logic                               s_axi_bvalid_o,
  input  wire logic                          s_axi_bready_i,
  output logic      [1:0]                    s_axi_bresp_o,
  input  wire logic                          s_axi_arvalid_i,
  output logic                               s_axi_arready_o,
  input  wire logic [cbf_pkg::ADDR_W-1:0]    s_axi_araddr_i,
  output logic                               s_axi_rvalid_o,
  input  wire logic                          s_axi_rready_i,
  output logic      [31:0]                   s_axi_rdata_o,
  output logic      [1:0]                    s_axi_rresp_o,
  // Engine transmit fetch
  input  wire logic                          tx_req_i,
  input  wire logic [$clog2(NBUF)-1:0]       tx_buf_i,
  output logic                               tx_frame_valid_o,
  output logic      [cbf_pkg::KEY_W-1:0]     tx_key_o,
  output logic                               tx_ext_o,
  output logic                               tx_remote_o,
  output logic                               tx_srr_o,
  output logic      [3:0]                    tx_len_o,
  output logic      [cbf_pkg::DATA_W-1:0]    tx_data_o,
  // Engine receive store
  input  wire logic                          rx_store_i,
  input  wire logic [$clog2(NBUF)-1:0]       rx_buf_i,
  input  wire logic [cbf_pkg::KEY_W-1:0]     rx_key_i,
  input  wire logic                          rx_ext_i,
  input  wire logic                          rx_remote_i,
  input  wire logic                          rx_srr_i,
  input  wire logic [3:0]                    rx_count_i,
  input  wire logic [cbf_pkg::DATA_W-1:0]    rx_data_i,
  input  wire logic [15:0]                   rx_stamp_i
);
  import cbf_pkg::*;

  localparam int unsigned BW   = $clog2(NBUF);
  localparam int unsigned MW   = BW + 3;
  localparam int unsigned NW   = NBUF * WORDS_PER_BUF;
  localparam int unsigned IDXW = ADDR_W - 2;

  // ===========================================================
  // State
  typedef struct packed {
    logic [NW-1:0][15:0]   mem;
    logic                  aw_got;
    logic [ADDR_W-1:0]     awaddr;
    logic                  w_got;
    logic [15:0]           wdata;
    logic [1:0]            wstrb;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  rvalid;
    logic [31:0]           rdata;
    logic [1:0]            rresp;
    logic                  tx_valid;
    logic [KEY_W-1:0]      tx_key;
    logic                  tx_ext;
    logic                  tx_remote;
    logic                  tx_srr;
    logic [3:0]            tx_len;
    logic [DATA_W-1:0]     tx_data;
    logic [7:0]            rx_cnt;
    logic [7:0]            tx_cnt;
  } cbf_state_t;

  cbf_state_t s_q;
  cbf_state_t s_d;

  // ===========================================================
  // Address decode
  logic [IDXW-1:0] w_idx;
  logic [IDXW-1:0] r_idx;
  logic            w_ok;
  logic            r_ok;
  logic            r_stat;
  logic [MW-1:0]   w_mi;
  logic [MW-1:0]   r_mi;

  assign w_idx  = s_q.awaddr[ADDR_W-1:2];
  assign r_idx  = s_axi_araddr_i[ADDR_W-1:2];
  // Odd word indices and buffers past the last are unmapped
  assign w_ok   = !w_idx[0] && (int'(w_idx[IDXW-1:4]) < int'(NBUF));
  assign r_ok   = !r_idx[0] && (int'(r_idx[IDXW-1:4]) < int'(NBUF));
  assign r_stat = (r_idx == STATUS_IDX);
  assign w_mi   = {w_idx[BW+3:4], w_idx[3:1]};
  assign r_mi   = {r_idx[BW+3:4], r_idx[3:1]};

  // ===========================================================
  // Transmit view of the selected buffer
  logic [MW-1:0]       t_base;
  logic [3:0][15:0]    t_data;
  logic [KEY_W-1:0]    u_key;
  logic                u_ext;
  logic                u_remote;
  logic                u_srr;
  logic [3:0]          u_len;
  logic [DATA_W-1:0]   u_data;

  assign t_base    = {tx_buf_i, 3'h0};
  assign t_data[3] = s_q.mem[t_base + MW'(SLOT_DATA12)];
  assign t_data[2] = s_q.mem[t_base + MW'(SLOT_DATA34)];
  assign t_data[1] = s_q.mem[t_base + MW'(SLOT_DATA56)];
  assign t_data[0] = s_q.mem[t_base + MW'(SLOT_DATA78)];

  cbf_tx_unpack u_unpack (
    .ctrl_i   (s_q.mem[t_base + MW'(SLOT_CTRL)]),
    .key_hi_i (s_q.mem[t_base + MW'(SLOT_KEYHI)]),
    .key_lo_i (s_q.mem[t_base + MW'(SLOT_KEYLO)]),
    .data_i   (t_data),
    .key_o    (u_key),
    .ext_o    (u_ext),
    .remote_o (u_remote),
    .srr_o    (u_srr),
    .len_o    (u_len),
    .data_o   (u_data)
  );

  // ===========================================================
  // Receive packing
  logic [MW-1:0] r_base;
  logic [15:0]   rx_hi;
  logic [15:0]   rx_lo;
  logic [3:0]    rx_len;

  assign r_base = {rx_buf_i, 3'h0};
  assign rx_len = (rx_count_i >= MAX_BYTES) ? MAX_BYTES : rx_count_i;

  always_comb begin
    rx_hi = 16'h0000;
    rx_lo = s_q.mem[r_base + MW'(SLOT_KEYLO)];
    if (rx_ext_i) begin
      rx_hi[STD_ID_LSB +: STD_ID_W] = rx_key_i[KEY_W-1 -: STD_ID_W];
      rx_hi[SRR_BIT]                = rx_srr_i;
      rx_hi[IDE_BIT]                = 1'b1;
      rx_hi[EXT_MID_W-1:0]          = rx_key_i[EXT_LOW_W +: EXT_MID_W];
      rx_lo[EXT_LOW_LSB +: EXT_LOW_W] = rx_key_i[EXT_LOW_W-1:0];
      rx_lo[EXT_RTR_BIT]              = rx_remote_i;
    end else begin
      // Low key word left as it was
      rx_hi[STD_ID_LSB +: STD_ID_W] = rx_key_i[STD_ID_W-1:0];
      rx_hi[STD_RTR_BIT]            = rx_remote_i;
    end
  end

  // ===========================================================
  // Next state
  always_comb begin
    s_d = s_q;

    // Write channels, taken in either order
    if (s_axi_awvalid_i && !s_q.aw_got && !s_q.bvalid) begin
      s_d.aw_got = 1'b1;
      s_d.awaddr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && !s_q.w_got && !s_q.bvalid) begin
      s_d.w_got = 1'b1;
      s_d.wdata = s_axi_wdata_i[15:0];
      s_d.wstrb = s_axi_wstrb_i[1:0];
    end
    if (s_q.bvalid && s_axi_bready_i) begin
      s_d.bvalid = 1'b0;
    end
    if (s_q.aw_got && s_q.w_got && !s_q.bvalid) begin
      s_d.aw_got = 1'b0;
      s_d.w_got  = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp  = w_ok ? RESP_OKAY : RESP_SLVERR;
      if (w_ok) begin
        if (s_q.wstrb[0]) begin
          s_d.mem[w_mi][7:0] = s_q.wdata[7:0];
        end
        if (s_q.wstrb[1]) begin
          s_d.mem[w_mi][15:8] = s_q.wdata[15:8];
        end
        if (w_idx[3:1] == SLOT_CTRL) begin
          s_d.mem[w_mi] = s_d.mem[w_mi] & CTRL_WR_MASK;
        end
      end
    end

    // Read channel
    if (s_q.rvalid && s_axi_rready_i) begin
      s_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid_i && !s_q.rvalid) begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = (r_ok || r_stat) ? RESP_OKAY : RESP_SLVERR;
      if (r_stat) begin
        s_d.rdata = {16'h0000, s_q.tx_cnt, s_q.rx_cnt};
      end else if (r_ok) begin
        s_d.rdata = {16'h0000, s_q.mem[r_mi]};
      end else begin
        s_d.rdata = 32'h0000_0000;
      end
    end

    // Receive store wins over a software write in the same cycle
    if (rx_store_i) begin
      s_d.mem[r_base + MW'(SLOT_KEYHI)] = rx_hi;
      s_d.mem[r_base + MW'(SLOT_KEYLO)] = rx_lo;
      // Whole payload taken from the bus, unused bytes carry junk
      s_d.mem[r_base + MW'(SLOT_DATA12)] = rx_data_i[63:48];
      s_d.mem[r_base + MW'(SLOT_DATA34)] = rx_data_i[47:32];
      s_d.mem[r_base + MW'(SLOT_DATA56)] = rx_data_i[31:16];
      s_d.mem[r_base + MW'(SLOT_DATA78)] = rx_data_i[15:0];
      s_d.mem[r_base + MW'(SLOT_STAMP)]  = rx_stamp_i;
      s_d.mem[r_base + MW'(SLOT_CTRL)][DLC_LSB +: DLC_W] = rx_len;
      s_d.rx_cnt = s_q.rx_cnt + 8'h01;
    end

    // Transmit fetch
    s_d.tx_valid = tx_req_i;
    if (tx_req_i) begin
      s_d.tx_key    = u_key;
      s_d.tx_ext    = u_ext;
      s_d.tx_remote = u_remote;
      s_d.tx_srr    = u_srr;
      s_d.tx_len    = u_len;
      s_d.tx_data   = u_data;
      s_d.tx_cnt    = s_q.tx_cnt + 8'h01;
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ===========================================================
  // Outputs
  assign s_axi_awready_o  = !s_q.aw_got && !s_q.bvalid;
  assign s_axi_wready_o   = !s_q.w_got && !s_q.bvalid;
  assign s_axi_bvalid_o   = s_q.bvalid;
  assign s_axi_bresp_o    = s_q.bresp;
  assign s_axi_arready_o  = !s_q.rvalid;
  assign s_axi_rvalid_o   = s_q.rvalid;
  assign s_axi_rdata_o    = s_q.rdata;
  assign s_axi_rresp_o    = s_q.rresp;
  assign tx_frame_valid_o = s_q.tx_valid;
  assign tx_key_o         = s_q.tx_key;
  assign tx_ext_o         = s_q.tx_ext;
  assign tx_remote_o      = s_q.tx_remote;
  assign tx_srr_o         = s_q.tx_srr;
  assign tx_len_o         = s_q.tx_len;
  assign tx_data_o        = s_q.tx_data;
endmodule

// *** tb/cbf_buffer_store_assertions.sv ***
`timescale 1ns/1ps
module cbf_buffer_store_assertions (
  input wire logic                      mclk_i,
  input wire logic                      reset_i,
  input wire logic                      s_axi_awvalid_i,
  input wire logic                      s_axi_awready_o,
  input wire logic                      s_axi_wvalid_i,
  input wire logic                      s_axi_wready_o,
  input wire logic                      s_axi_bvalid_o,
  input wire logic                      s_axi_arvalid_i,
  input wire logic                      s_axi_arready_o,
  input wire logic                      s_axi_rvalid_o,
  input wire logic                      s_axi_rready_i,
  input wire logic [31:0]               s_axi_rdata_o,
  input wire logic                      tx_req_i,
  input wire logic                      tx_frame_valid_o,
  input wire logic [cbf_pkg::KEY_W-1:0] tx_key_o,
  input wire logic                      tx_ext_o,
  input wire logic                      tx_remote_o,
  input wire logic                      tx_srr_o,
  input wire logic [3:0]                tx_len_o,
  input wire logic [cbf_pkg::DATA_W-1:0] tx_data_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  // ======
  // Write handshake steps, then read and transmit checks
  sequence s_both_taken;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
  endsequence
  sequence s_resp_late;
    !s_axi_bvalid_o ##1 s_axi_bvalid_o;
  endsequence
  a_wr_answer: assert property (s_both_taken |=> s_resp_late)
    else $error("write response timing wrong");
  a_rd_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("read answer missing");
  a_rd_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
    s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read answer not held");
  a_rd_upper: assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:16] == 16'h0000)
    else $error("read upper half not zero");
  a_tx_pulse: assert property (1'b1 |=> tx_frame_valid_o == $past(tx_req_i))
    else $error("transmit valid not one cycle after request");
  a_tx_len_cap: assert property (tx_frame_valid_o |-> tx_len_o <= 4'h8)
    else $error("transmit length above eight");
  a_tx_sub_set: assert property (tx_frame_valid_o && tx_ext_o |-> tx_srr_o)
    else $error("extended frame substitute bit not one");
  a_tx_std_key: assert property (tx_frame_valid_o && !tx_ext_o |->
    tx_key_o[28:11] == 18'h00000 && !tx_srr_o)
    else $error("standard key wider than 11 bits");
  a_tx_remote: assert property (tx_frame_valid_o && tx_remote_o |->
    tx_len_o == 4'h0 && tx_data_o == 64'h0)
    else $error("remote frame carries payload");
  a_tx_unused: assert property (tx_frame_valid_o |->
    (tx_data_o << {tx_len_o, 3'b000}) == 64'h0)
    else $error("unused payload bytes not cleared");
endmodule
bind cbf_buffer_store cbf_buffer_store_assertions chk_u (.mclk_i, .reset_i, .s_axi_awvalid_i,
  .s_axi_awready_o, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bvalid_o, .s_axi_arvalid_i,
  .s_axi_arready_o, .s_axi_rvalid_o, .s_axi_rready_i, .s_axi_rdata_o, .tx_req_i,
  .tx_frame_valid_o, .tx_key_o, .tx_ext_o, .tx_remote_o, .tx_srr_o, .tx_len_o, .tx_data_o);

// *** tb/cbf_engine_model.sv ***
`timescale 1ns/1ps
module cbf_engine_model #(
  parameter int unsigned NBUF = 16
) (
  input  wire logic                       mclk_i,
  output logic                            tx_req_o,
  output logic [$clog2(NBUF)-1:0]         tx_buf_o,
  output logic                            rx_store_o,
  output logic [$clog2(NBUF)-1:0]         rx_buf_o,
  output logic [cbf_pkg::KEY_W-1:0]       rx_key_o,
  output logic                            rx_ext_o,
  output logic                            rx_remote_o,
  output logic                            rx_sub_o,
  output logic [3:0]                      rx_count_o,
  output logic [cbf_pkg::DATA_W-1:0]      rx_data_o,
  output logic [15:0]                     rx_stamp_o
);
  import cbf_pkg::*;
  localparam int unsigned BW = $clog2(NBUF);
  initial begin
    {tx_req_o, tx_buf_o, rx_store_o, rx_buf_o} = '0;
    {rx_key_o, rx_ext_o, rx_remote_o, rx_sub_o} = '0;
    {rx_count_o, rx_data_o, rx_stamp_o} = '0;
  end
  // ======
  // Fetch one buffer, return with fields settled
  task automatic fetch(input logic [BW-1:0] b);
    @(posedge mclk_i);
    tx_req_o <= 1'b1;
    tx_buf_o <= b;
    @(posedge mclk_i);
    tx_req_o <= 1'b0;
    tx_buf_o <= ~b;
    #1;
  endtask
  // ======
  // Store one received frame, then scramble the key, data, stamp and substitute lines
  task automatic store(input logic [BW-1:0] b, input logic [KEY_W-1:0] k,
                       input logic e, input logic rm, input logic s,
                       input logic [3:0] n, input logic [DATA_W-1:0] d,
                       input logic [15:0] t);
    @(posedge mclk_i);
    rx_store_o <= 1'b1;
    {rx_buf_o, rx_key_o, rx_ext_o, rx_remote_o} <= {b, k, e, rm};
    rx_sub_o <= s;
    {rx_count_o, rx_data_o, rx_stamp_o} <= {n, d, t};
    @(posedge mclk_i);
    rx_store_o <= 1'b0;
    {rx_key_o, rx_data_o, rx_stamp_o, rx_sub_o} <= ~{k, d, t, s};
  endtask
endmodule

// *** tb/tb_cbf_buffer_store.sv ***
`timescale 1ns/1ps
module tb_cbf_buffer_store;
  import cbf_pkg::*;
  localparam logic [KEY_W-1:0] K1 = 29'h1ABCDEF5;
  localparam logic [KEY_W-1:0] K2 = 29'h0F0F1234;
  logic        mclk_i, reset_i, aw_valid, aw_ready, w_valid, w_ready, b_valid, b_ready;
  logic        ar_valid, ar_ready, r_valid, r_ready, tx_req, fv, ext, rem, sub;
  logic        rx_stb, r_ext, r_rem, r_sub;
  logic [11:0] aw_addr, ar_addr;
  logic [31:0] w_data, r_data;
  logic [3:0]  w_strb, tx_buf, r_buf, len, r_cnt;
  logic [1:0]  b_resp, r_resp;
  logic [28:0] key, r_key;
  logic [63:0] data, r_dat;
  logic [15:0] r_stamp;
  int          err_count = 0, cmp_count = 0;
  cbf_buffer_store #(.NBUF(16)) dut_u (.mclk_i(mclk_i), .reset_i(reset_i),
    .s_axi_awvalid_i(aw_valid), .s_axi_awready_o(aw_ready), .s_axi_awaddr_i(aw_addr),
    .s_axi_wvalid_i(w_valid), .s_axi_wready_o(w_ready), .s_axi_wdata_i(w_data),
    .s_axi_wstrb_i(w_strb), .s_axi_bvalid_o(b_valid), .s_axi_bready_i(b_ready),
    .s_axi_bresp_o(b_resp), .s_axi_arvalid_i(ar_valid), .s_axi_arready_o(ar_ready),
    .s_axi_araddr_i(ar_addr), .s_axi_rvalid_o(r_valid), .s_axi_rready_i(r_ready),
    .s_axi_rdata_o(r_data), .s_axi_rresp_o(r_resp), .tx_req_i(tx_req), .tx_buf_i(tx_buf),
    .tx_frame_valid_o(fv), .tx_key_o(key), .tx_ext_o(ext), .tx_remote_o(rem),
    .tx_srr_o(sub), .tx_len_o(len), .tx_data_o(data), .rx_store_i(rx_stb), .rx_buf_i(r_buf),
    .rx_key_i(r_key), .rx_ext_i(r_ext), .rx_remote_i(r_rem), .rx_srr_i(r_sub),
    .rx_count_i(r_cnt), .rx_data_i(r_dat), .rx_stamp_i(r_stamp));
  cbf_engine_model #(.NBUF(16)) eng_u (.mclk_i(mclk_i), .tx_req_o(tx_req), .tx_buf_o(tx_buf),
    .rx_store_o(rx_stb), .rx_buf_o(r_buf), .rx_key_o(r_key), .rx_ext_o(r_ext),
    .rx_remote_o(r_rem), .rx_sub_o(r_sub), .rx_count_o(r_cnt), .rx_data_o(r_dat),
    .rx_stamp_o(r_stamp));
  // ======
  // Shared tasks
  task automatic chk(input string n, input logic [63:0] s, input logic [63:0] e);
    cmp_count++;
    if (s !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  function automatic logic [11:0] ad(input int b, input logic [3:0] o);
    return 12'(b * 64 + o * 4);
  endfunction
  task automatic axi_wr(input logic [11:0] a, input logic [15:0] v, output logic [1:0] r);
    bit ga = 0, gw = 0;
    @(posedge mclk_i);
    {aw_valid, w_valid, b_ready} <= 3'b111;
    aw_addr <= a;
    w_data <= {16'h0000, v};
    while (!(ga && gw)) begin
      @(posedge mclk_i);
      if (!ga && aw_ready) begin
        ga = 1;
        aw_valid <= 1'b0;
      end
      if (!gw && w_ready) begin
        gw = 1;
        w_valid <= 1'b0;
      end
    end
    while (!b_valid) @(posedge mclk_i);
    r = b_resp;
    b_ready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge mclk_i);
    {ar_valid, r_ready} <= 2'b11;
    ar_addr <= a;
    do @(posedge mclk_i); while (!ar_ready);
    ar_valid <= 1'b0;
    do @(posedge mclk_i); while (!r_valid);
    {d, r} = {r_data, r_resp};
    r_ready <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [15:0] v);
    logic [1:0] r;
    axi_wr(a, v, r);
    chk("bresp", r, RESP_OKAY);
  endtask
  task automatic rd(input logic [11:0] a, input logic [15:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(a, d, r);
    chk("rdata", d, {16'h0000, e});
    chk("rresp", r, RESP_OKAY);
  endtask
  task automatic wr_data(input int b, input logic [63:0] d);
    for (int i = 0; i < 4; i++) wr(ad(b, OFS_DATA12 - 4'(2 * i)), d[63 - 16 * i -: 16]);
  endtask
  // ======
  // Scenarios
  task automatic t_std_tx();
    rd(ad(1, OFS_KEYHI), 16'h0000);
    wr(ad(1, OFS_CTRL), 16'h3F25);
    rd(ad(1, OFS_CTRL), 16'h3025);
    wr(ad(1, OFS_KEYHI), {11'h5A3, 5'h07});
    wr(ad(1, OFS_KEYLO), 16'hFFFF);
    wr_data(1, 64'h1122_3344_5566_7788);
    eng_u.fetch(4'h1);
    chk("tx_valid", fv, 1'b1);
    chk("tx_key", key, 29'h5A3);
    chk("tx_flags", {ext, rem, sub}, 3'b000);
    chk("tx_len", len, 4'h3);
    chk("tx_data", data, 64'h1122_3300_0000_0000);
  endtask
  task automatic t_ext_tx();
    wr(ad(2, OFS_CTRL), 16'hF000);
    wr(ad(2, OFS_KEYHI), {K1[28:18], 2'b11, K1[17:15]});
    wr(ad(2, OFS_KEYLO), {K1[14:0], 1'b0});
    wr_data(2, 64'h0102_0304_0506_0708);
    wr(ad(3, OFS_CTRL), 16'h4000);
    wr(ad(3, OFS_KEYHI), {K1[28:18], 2'b01, K1[17:15]});
    wr(ad(3, OFS_KEYLO), {K1[14:0], 1'b1});
    wr_data(3, 64'hDEAD_BEEF_CAFE_F00D);
    eng_u.fetch(4'h2);
    chk("tx_key", key, K1);
    chk("tx_flags", {ext, rem, sub}, 3'b101);
    chk("tx_len", len, 4'h8);
    chk("tx_data", data, 64'h0102_0304_0506_0708);
    eng_u.fetch(4'h3);
    chk("tx_flags", {ext, rem, sub}, 3'b111);
    chk("tx_len", len, 4'h0);
    chk("tx_data", data, 64'h0);
  endtask
  task automatic t_rx();
    eng_u.store(4'h4, K2, 1'b1, 1'b0, 1'b0, 4'h2, 64'hA1B2_C3D4_E5F6_0718, 16'h1234);
    rd(ad(4, OFS_KEYHI), {K2[28:18], 2'b01, K2[17:15]});
    rd(ad(4, OFS_KEYLO), {K2[14:0], 1'b0});
    rd(ad(4, OFS_DATA12), 16'hA1B2);
    rd(ad(4, OFS_STAMP), 16'h1234);
    rd(ad(4, OFS_CTRL), 16'h2000);
    eng_u.store(4'h5, 29'h7FF, 1'b0, 1'b1, 1'b1, 4'hC, 64'h0, 16'h0000);
    rd(ad(5, OFS_KEYHI), 16'hFFF0);
    rd(ad(5, OFS_CTRL), 16'h8000);
    eng_u.store(4'h6, K1, 1'b1, 1'b1, 1'b1, 4'h0, 64'h5555_AAAA_0F0F_F0F0, 16'h00FF);
    rd(ad(6, OFS_KEYHI), {K1[28:18], 2'b11, K1[17:15]});
    rd(ad(6, OFS_KEYLO), {K1[14:0], 1'b1});
    rd(ad(6, OFS_CTRL), 16'h0000);
  endtask
  task automatic t_err();
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(ad(0, 4'h1), d, r);
    chk("rresp", r, RESP_SLVERR);
    chk("rdata", d, 32'h0);
    axi_wr(12'h400, 16'h00FF, r);
    chk("bresp", r, RESP_SLVERR);
    rd(12'h400, 16'h0303);
  endtask
  task automatic results();
    if (err_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // ======
  // Clock, reset, sequence and watchdog
  initial begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end
  initial begin
    reset_i = 1'b1;
    {aw_valid, w_valid, b_ready, ar_valid, r_ready} = '0;
    {aw_addr, ar_addr, w_data} = '0;
    w_strb = 4'hF;
    repeat (4) @(posedge mclk_i);
    reset_i <= 1'b0;
    t_std_tx();
    t_ext_tx();
    t_rx();
    t_err();
    results();
  end
  initial begin
    repeat (5000) @(posedge mclk_i);
    err_count++;
    results();
  end
endmodule
